/* File: gii_assertions.sv */
// concurrent checks on the bus wires joining the two ends
`timescale 1ns/1ns
module gii_assertions (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // instrument drive
   input  wire logic [7:0] dio_dev_o,
   input  wire logic [7:0] dio_dev_oe_n,
   input  wire logic       eoi_dev_n,
   input  wire logic       dav_dev_n,
   input  wire logic       nrfd_dev_n,
   input  wire logic       ndac_dev_n,
   input  wire logic       srq_dev_n,
   // controller drive and resolved lines
   input  wire logic       dav_ctl_n,
   input  wire logic       atn_n,
   input  wire logic       eoi_n,
   input  wire logic       dav_n,
   input  wire logic       nrfd_n,
   input  wire logic       ndac_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////////
   a_dev_dav_ready: assert property ($fell(dav_dev_n) |-> $past(nrfd_n) && !$past(ndac_n))
      else $error("instrument data-valid without ready");
   a_ctl_dav_ready: assert property ($fell(dav_ctl_n) |-> $past(nrfd_n) && !$past(ndac_n))
      else $error("controller data-valid without ready");
   a_dev_dav_release: assert property (!dav_dev_n && ndac_n |-> ##[1:4] dav_dev_n)
      else $error("instrument data-valid held after accept");
   a_dev_accept_byte: assert property ($fell(dav_ctl_n) && !atn_n |-> ##[1:3] (!nrfd_dev_n && ndac_dev_n))
      else $error("command byte not accepted");
   a_take_once: assert property ($rose(ndac_dev_n) && !nrfd_dev_n |-> !$past(dav_n))
      else $error("accepted released without data-valid");
   a_no_identify: assert property (!atn_n && !eoi_n |-> &dio_dev_oe_n)
      else $error("instrument answered identify");
   a_data_steady: assert property (!dav_dev_n && !$past(dav_dev_n) |-> $stable(dio_dev_o) && $stable(dio_dev_oe_n))
      else $error("data changed while valid");
   a_end_with_data: assert property (!eoi_dev_n |-> !(&dio_dev_oe_n))
      else $error("end marker without data byte");
   a_idle_at_release: assert property ($fell(rst) |-> dav_dev_n && eoi_dev_n && srq_dev_n && &dio_dev_oe_n)
      else $error("instrument lines not released after reset");
endmodule : gii_assertions

/* File: gii_bus_if.sv */
// bus wires between instrument end and controller end, all lines low-true
`timescale 1ns/1ns
interface gii_bus_if;
   // each party drives an active-low line only while its enable is low
   logic [7:0] dio_dev_o;
   logic [7:0] dio_dev_oe_n;
   logic [7:0] dio_ctl_o;
   logic [7:0] dio_ctl_oe_n;
   logic       eoi_dev_n;
   logic       eoi_ctl_n;
   logic       dav_dev_n;
   logic       dav_ctl_n;
   logic       nrfd_dev_n;
   logic       nrfd_ctl_n;
   logic       ndac_dev_n;
   logic       ndac_ctl_n;
   logic       srq_dev_n;
   logic       atn_n;
   logic       ifc_n;
   logic       ren_n;
   logic [7:0] dio_n;
   logic       eoi_n;
   logic       dav_n;
   logic       nrfd_n;
   logic       ndac_n;
   logic       srq_n;
   // wired-or of low-true open-collector lines
   assign dio_n  = (dio_dev_o | dio_dev_oe_n) & (dio_ctl_o | dio_ctl_oe_n);
   assign eoi_n  = eoi_dev_n & eoi_ctl_n;
   assign dav_n  = dav_dev_n & dav_ctl_n;
   assign nrfd_n = nrfd_dev_n & nrfd_ctl_n;
   assign ndac_n = ndac_dev_n & ndac_ctl_n;
   assign srq_n  = srq_dev_n;
   modport dev (output dio_dev_o, dio_dev_oe_n, eoi_dev_n, dav_dev_n, nrfd_dev_n,
                ndac_dev_n, srq_dev_n,
                input dio_n, eoi_n, dav_n, nrfd_n, ndac_n, atn_n, ifc_n, ren_n);
   modport ctl (output dio_ctl_o, dio_ctl_oe_n, eoi_ctl_n, dav_ctl_n, nrfd_ctl_n,
                ndac_ctl_n, atn_n, ifc_n, ren_n,
                input dio_n, eoi_n, dav_n, nrfd_n, ndac_n, srq_n);
endinterface : gii_bus_if

/* File: gii_ctl_end.sv */
// controller end: sends commands and data bytes, reads bytes back
`timescale 1ns/1ns
module gii_ctl_end
   import gii_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // bus
   gii_bus_if.ctl           bus,
   // byte send request: atn set sends it as a command
   input  wire logic        tx_valid,
   output logic             tx_ready,
   input  wire logic [7:0]  tx_data,
   input  wire logic        tx_atn,
   input  wire logic        tx_end,
   // listen request: accept bytes sourced by the device
   input  wire logic        rx_enable,
   output logic             rx_valid,
   output logic [7:0]       rx_data,
   output logic             rx_end,
   // uniline controls and service request
   input  wire logic        ifc_req,
   input  wire logic        ren_req,
   output logic             srq
);
   gii_src_t                src_state;
   logic [3:0]              cnt;
   logic                    atn_q;
   gii_acc_t                acc_state;

   assign tx_ready = (src_state == GII_SRC_IDLE);
   assign srq      = ~bus.srq_n;

   ////////////////////////////////////////////////////////////////////////
   // management lines
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bus.ifc_n <= 1'b1;
         bus.ren_n <= 1'b1;
      end else begin
         bus.ifc_n <= ~ifc_req;
         bus.ren_n <= ~ren_req;
      end
   end

   // atn from the first command byte until data or listening
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         atn_q <= 1'b0;
      end else if (tx_valid && tx_ready) begin
         atn_q <= tx_atn;
      end else if (rx_enable) begin
         atn_q <= 1'b0;
      end
   end
   assign bus.atn_n = ~atn_q;

   ////////////////////////////////////////////////////////////////////////
   // source handshake
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         src_state        <= GII_SRC_IDLE;
         cnt              <= '0;
         bus.dio_ctl_o    <= 8'hFF;
         bus.dio_ctl_oe_n <= 8'hFF;
         bus.eoi_ctl_n    <= 1'b1;
         bus.dav_ctl_n    <= 1'b1;
      end else begin
         case (src_state)
            GII_SRC_IDLE: begin
               if (tx_valid) begin
                  bus.dio_ctl_o    <= ~tx_data;
                  bus.dio_ctl_oe_n <= 8'h00;
                  bus.eoi_ctl_n    <= ~(tx_end & ~tx_atn);
                  cnt              <= 4'(SETTLE_CYC);
                  src_state        <= GII_SRC_SETTLE;
               end
            end
            GII_SRC_SETTLE: begin
               if (cnt != 4'h0) begin
                  cnt <= cnt - 4'h1;
               end else if (bus.nrfd_n && !bus.ndac_n) begin
                  bus.dav_ctl_n <= 1'b0;
                  src_state     <= GII_SRC_VALID;
               end
            end
            GII_SRC_VALID: begin
               if (bus.ndac_n) begin
                  bus.dav_ctl_n    <= 1'b1;
                  bus.dio_ctl_oe_n <= 8'hFF;
                  bus.eoi_ctl_n    <= 1'b1;
                  src_state        <= GII_SRC_WAIT;
               end
            end
            GII_SRC_WAIT: begin
               if (!bus.ndac_n) begin
                  src_state <= GII_SRC_IDLE;
               end
            end
            default: src_state <= GII_SRC_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // acceptor handshake for bytes read back
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acc_state      <= GII_ACC_READY;
         bus.nrfd_ctl_n <= 1'b1;
         bus.ndac_ctl_n <= 1'b1;
         rx_valid       <= 1'b0;
         rx_data        <= '0;
         rx_end         <= 1'b0;
      end else begin
         rx_valid <= 1'b0;
         case (acc_state)
            GII_ACC_READY: begin
               bus.nrfd_ctl_n <= 1'b1;
               bus.ndac_ctl_n <= ~rx_enable;
               if (rx_enable && !bus.dav_n) begin
                  acc_state <= GII_ACC_TAKE;
               end
            end
            GII_ACC_TAKE: begin
               rx_data        <= ~bus.dio_n;
               rx_end         <= ~bus.eoi_n;
               rx_valid       <= 1'b1;
               bus.nrfd_ctl_n <= 1'b0;
               bus.ndac_ctl_n <= 1'b1;
               acc_state      <= GII_ACC_HOLD;
            end
            GII_ACC_HOLD: begin
               if (bus.dav_n) begin
                  bus.ndac_ctl_n <= 1'b0;
                  acc_state      <= GII_ACC_READY;
               end
            end
            default: acc_state <= GII_ACC_READY;
         endcase
      end
   end
endmodule : gii_ctl_end

/* File: gii_dev_end.sv */
// instrument end: handshakes, addressing, poll, clear, trigger, remote/local
`timescale 1ns/1ns
// Functional notes
// - source bytes with interlocked data-valid handshake
// - accept bytes, none lost or duplicated
// - talk only when addressed; listen address untalks
// - listen only when addressed; talk address unlistens
// - drive service request when requested
// - remote and local modes under bus control
// - no parallel poll reply ever
// - clear on universal or addressed clear
// - trigger on addressed group execute trigger
// - primary addresses only, no controller
// - ignore others; talk address triggers modes a/b
// - controller holds attention for command bytes
// - all lines low-true
// - addressed command sequence via addressing bytes
// - serial poll returns one status byte
// - trigger without addressing if still listener
// - interface clear idles; remote drops with enable
// - read sequence sources data bytes
// - write sequence accepts data bytes
// - configurable address, default seventeen
// - end-or-identify marks last byte
// - data-valid only when ready, released on accepted
// - interface clear keeps remote state
module gii_dev_end
   import gii_pkg::*;
#(
   parameter logic [4:0]    ADDR_DEFAULT = DEFAULT_ADDR
)(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // bus
   gii_bus_if.dev           bus,
   // configuration
   input  wire logic [4:0]  my_addr,
   input  wire logic        addr_load,
   input  wire logic        trigger_on_talk_mode_a,
   input  wire logic        trigger_on_talk_mode_b,
   // outgoing device-dependent data
   input  wire logic        tx_valid,
   output logic             tx_ready,
   input  wire logic [7:0]  tx_data,
   input  wire logic        tx_end,
   // incoming device-dependent data to the parser
   output logic             rx_valid,
   output logic [7:0]       rx_data,
   output logic             rx_end,
   // service request and status
   input  wire logic        rsv_req,
   input  wire logic [7:0]  status_byte,
   // events and state
   output logic             dev_clear,
   output logic             dev_trigger,
   output logic             remote,
   output logic             lockout,
   output logic             talker,
   output logic             listener
);
   logic [4:0]              addr;
   logic                    spoll;
   logic                    srq_pend;
   gii_src_t                src_state;
   gii_acc_t                acc_state;
   logic [3:0]              cnt;
   logic [7:0]              cmd;
   logic                    cmd_stb;
   logic                    atn;
   logic                    is_mla;
   logic                    is_mta;
   logic                    ifc;
   logic                    ren;
   logic                    spoll_sent;
   logic                    src_active;

   assign atn    = ~bus.atn_n;
   assign ifc    = ~bus.ifc_n;
   assign ren    = ~bus.ren_n;
   assign is_mla = (cmd[6:5] == GRP_LISTEN) && (cmd[4:0] == addr);
   assign is_mta = (cmd[6:5] == GRP_TALK) && (cmd[4:0] == addr);
   assign src_active = talker && !atn;
   assign tx_ready = src_active && !spoll && (src_state == GII_SRC_IDLE);
   assign bus.dio_dev_oe_n = (src_state == GII_SRC_IDLE) ? 8'hFF : 8'h00;
   // no parallel poll: the data lines are only driven by the source handshake
   assign bus.srq_dev_n = ~srq_pend;

   ////////////////////////////////////////////////////////////////////////
   // bus address, loaded from configuration after reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         addr <= ADDR_DEFAULT;
      end else if (addr_load && my_addr != ADDR_UNIV) begin
         addr <= my_addr;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // acceptor handshake; command bytes under attention, data otherwise
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acc_state      <= GII_ACC_READY;
         bus.nrfd_dev_n <= 1'b1;
         bus.ndac_dev_n <= 1'b1;
         cmd            <= '0;
         cmd_stb        <= 1'b0;
         rx_valid       <= 1'b0;
         rx_data        <= '0;
         rx_end         <= 1'b0;
      end else begin
         cmd_stb  <= 1'b0;
         rx_valid <= 1'b0;
         case (acc_state)
            GII_ACC_READY: begin
               // only take part while addressed or attention is set
               if (atn || listener) begin
                  bus.nrfd_dev_n <= 1'b1;
                  bus.ndac_dev_n <= 1'b0;
                  if (!bus.dav_n) begin
                     acc_state <= GII_ACC_TAKE;
                  end
               end else begin
                  bus.nrfd_dev_n <= 1'b1;
                  bus.ndac_dev_n <= 1'b1;
               end
            end
            GII_ACC_TAKE: begin
               bus.nrfd_dev_n <= 1'b0;
               bus.ndac_dev_n <= 1'b1;
               if (atn) begin
                  cmd     <= ~bus.dio_n & 8'h7F;
                  cmd_stb <= 1'b1;
               end else if (listener) begin
                  rx_data  <= ~bus.dio_n;
                  rx_end   <= ~bus.eoi_n;
                  rx_valid <= 1'b1;
               end
               acc_state <= GII_ACC_HOLD;
            end
            GII_ACC_HOLD: begin
               // wait for data-valid release so a byte is never taken twice
               if (bus.dav_n) begin
                  bus.ndac_dev_n <= 1'b0;
                  acc_state      <= GII_ACC_READY;
               end
            end
            default: acc_state <= GII_ACC_READY;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // addressing, poll mode, clear and trigger decode
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         talker      <= 1'b0;
         listener    <= 1'b0;
         spoll       <= 1'b0;
         dev_clear   <= 1'b0;
         dev_trigger <= 1'b0;
      end else begin
         dev_clear   <= 1'b0;
         dev_trigger <= 1'b0;
         if (ifc) begin
            talker   <= 1'b0;
            listener <= 1'b0;
         end else if (cmd_stb) begin
            if (is_mla) begin
               listener <= 1'b1;
               talker   <= 1'b0;
            end else if (is_mta) begin
               talker   <= 1'b1;
               listener <= 1'b0;
               if (trigger_on_talk_mode_a || trigger_on_talk_mode_b) begin
                  dev_trigger <= 1'b1;
               end
            end else if (cmd == CMD_UNL) begin
               listener <= 1'b0;
            end else if (cmd == CMD_UNT || cmd[6:5] == GRP_TALK) begin
               talker <= 1'b0;
            end
            if (cmd == CMD_DCL || (cmd == CMD_SDC && listener)) begin
               dev_clear <= 1'b1;
            end
            if (cmd == CMD_GET && listener) begin
               dev_trigger <= 1'b1;
            end
            if (cmd == CMD_SPE) begin
               spoll <= 1'b1;
            end else if (cmd == CMD_SPD) begin
               spoll <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // remote/local and lockout
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         remote  <= 1'b0;
         lockout <= 1'b0;
      end else if (!ren) begin
         remote  <= 1'b0;
         lockout <= 1'b0;
      end else if (cmd_stb) begin
         if (is_mla) begin
            remote <= 1'b1;
         end else if (cmd == CMD_GTL && listener) begin
            remote <= 1'b0;
         end
         if (cmd == CMD_LLO) begin
            lockout <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // service request; request set wins over poll clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         srq_pend <= 1'b0;
      end else if (rsv_req) begin
         srq_pend <= 1'b1;
      end else if (spoll_sent) begin
         srq_pend <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // source handshake: status byte in poll mode, else user data
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         src_state     <= GII_SRC_IDLE;
         cnt           <= '0;
         bus.dio_dev_o <= 8'hFF;
         bus.eoi_dev_n <= 1'b1;
         bus.dav_dev_n <= 1'b1;
         spoll_sent    <= 1'b0;
      end else begin
         spoll_sent <= 1'b0;
         case (src_state)
            GII_SRC_IDLE: begin
               if (src_active && spoll) begin
                  bus.dio_dev_o <= ~(status_byte | (8'(srq_pend) << SRQ_BIT));
                  bus.eoi_dev_n <= 1'b1;
                  cnt           <= 4'(SETTLE_CYC);
                  spoll_sent    <= 1'b1;
                  src_state     <= GII_SRC_SETTLE;
               end else if (tx_valid && tx_ready) begin
                  bus.dio_dev_o <= ~tx_data;
                  bus.eoi_dev_n <= ~tx_end;
                  cnt           <= 4'(SETTLE_CYC);
                  src_state     <= GII_SRC_SETTLE;
               end
            end
            GII_SRC_SETTLE: begin
               if (!src_active) begin
                  src_state <= GII_SRC_IDLE;
               end else if (cnt != 4'h0) begin
                  cnt <= cnt - 4'h1;
               end else if (bus.nrfd_n && !bus.ndac_n) begin
                  bus.dav_dev_n <= 1'b0;
                  src_state     <= GII_SRC_VALID;
               end
            end
            GII_SRC_VALID: begin
               if (bus.ndac_n || !src_active) begin
                  bus.dav_dev_n <= 1'b1;
                  bus.eoi_dev_n <= 1'b1;
                  src_state     <= GII_SRC_WAIT;
               end
            end
            GII_SRC_WAIT: begin
               // poll mode holds here until attention returns or talker drops: one byte only
               if (!bus.ndac_n && !(spoll && src_active)) begin
                  src_state <= GII_SRC_IDLE;
               end else if (atn) begin
                  src_state <= GII_SRC_IDLE;
               end
            end
            default: src_state <= GII_SRC_IDLE;
         endcase
      end
   end
endmodule : gii_dev_end

/* File: gii_pkg.sv */
// shared constants and types for the instrument bus port and its controller
package gii_pkg;
   localparam int          DATA_W         = 8;
   localparam logic [4:0]  DEFAULT_ADDR   = 5'h11;
   localparam logic [4:0]  CTRL_ADDR      = 5'h15;
   // multiline command codes, true-logic values
   localparam logic [7:0]  CMD_GTL        = 8'h01;
   localparam logic [7:0]  CMD_SDC        = 8'h04;
   localparam logic [7:0]  CMD_GET        = 8'h08;
   localparam logic [7:0]  CMD_LLO        = 8'h11;
   localparam logic [7:0]  CMD_DCL        = 8'h14;
   localparam logic [7:0]  CMD_SPE        = 8'h18;
   localparam logic [7:0]  CMD_SPD        = 8'h19;
   localparam logic [7:0]  CMD_UNL        = 8'h3F;
   localparam logic [7:0]  CMD_UNT        = 8'h5F;
   localparam logic [1:0]  GRP_LISTEN     = 2'h1;
   localparam logic [1:0]  GRP_TALK       = 2'h2;
   localparam logic [4:0]  ADDR_UNIV      = 5'h1F;
   localparam int          SRQ_BIT        = 6;
   // handshake settle time before asserting data-valid
   localparam int          CLK_MHZ        = 250;
   localparam int          SETTLE_NS      = 8;
   localparam int          SETTLE_CYC     = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   typedef enum logic [1:0] {GII_SRC_IDLE, GII_SRC_SETTLE, GII_SRC_VALID, GII_SRC_WAIT} gii_src_t;
   typedef enum logic [1:0] {GII_ACC_READY, GII_ACC_TAKE, GII_ACC_HOLD} gii_acc_t;
endpackage : gii_pkg

/* File: gpib_instrument_interface_tb_top.sv */
// self-checking bench: controller end and instrument end on one bus
`timescale 1ns/1ns
module gpib_instrument_interface_tb_top;
   import gii_pkg::*;
   localparam logic [7:0] CT = {1'b0, GRP_TALK, CTRL_ADDR};
   localparam logic [7:0] CL = {1'b0, GRP_LISTEN, CTRL_ADDR};
   localparam logic [7:0] DT = {1'b0, GRP_TALK, DEFAULT_ADDR};
   localparam logic [7:0] DL = {1'b0, GRP_LISTEN, DEFAULT_ADDR};
   localparam logic [7:0] L5 = {1'b0, GRP_LISTEN, 5'h05};
   logic       clk, rst;
   logic       c_tx_valid, c_tx_ready, c_tx_atn, c_tx_end, c_rx_en, c_rx_valid, c_rx_end;
   logic [7:0] c_tx_data, c_rx_data, d_tx_data, d_rx_data, d_status, d_last;
   logic       c_ifc, c_ren, c_srq, d_load, d_tma, d_tmb, d_tx_valid, d_tx_ready, d_tx_end;
   logic       d_rx_valid, d_rx_end, d_rsv, d_clear, d_trig, d_remote, d_lockout;
   logic       d_talker, d_listener, d_end;
   logic [4:0] d_addr;
   int         num_errors = 0, n_checks = 0, n_trig = 0, n_clr = 0, n_rx = 0, cyc = 0;
   gii_bus_if bus ();
   gii_ctl_end i_gii_ctl_end (.clk(clk), .rst(rst), .bus(bus), .tx_valid(c_tx_valid),
      .tx_ready(c_tx_ready), .tx_data(c_tx_data), .tx_atn(c_tx_atn), .tx_end(c_tx_end),
      .rx_enable(c_rx_en), .rx_valid(c_rx_valid), .rx_data(c_rx_data), .rx_end(c_rx_end),
      .ifc_req(c_ifc), .ren_req(c_ren), .srq(c_srq));
   gii_dev_end i_gii_dev_end (.clk(clk), .rst(rst), .bus(bus), .my_addr(d_addr),
      .addr_load(d_load), .trigger_on_talk_mode_a(d_tma), .trigger_on_talk_mode_b(d_tmb),
      .tx_valid(d_tx_valid), .tx_ready(d_tx_ready), .tx_data(d_tx_data), .tx_end(d_tx_end),
      .rx_valid(d_rx_valid), .rx_data(d_rx_data), .rx_end(d_rx_end), .rsv_req(d_rsv),
      .status_byte(d_status), .dev_clear(d_clear), .dev_trigger(d_trig), .remote(d_remote),
      .lockout(d_lockout), .talker(d_talker), .listener(d_listener));
   gii_assertions i_gii_assertions (.clk(clk), .rst(rst), .dio_dev_o(bus.dio_dev_o),
      .dio_dev_oe_n(bus.dio_dev_oe_n), .eoi_dev_n(bus.eoi_dev_n), .dav_dev_n(bus.dav_dev_n),
      .nrfd_dev_n(bus.nrfd_dev_n), .ndac_dev_n(bus.ndac_dev_n), .srq_dev_n(bus.srq_dev_n),
      .dav_ctl_n(bus.dav_ctl_n), .atn_n(bus.atn_n), .eoi_n(bus.eoi_n), .dav_n(bus.dav_n),
      .nrfd_n(bus.nrfd_n), .ndac_n(bus.ndac_n));
   always #2 clk = ~clk;
   // one-cycle pulses are tallied, not polled
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (d_trig === 1'b1) n_trig <= n_trig + 1;
      if (d_clear === 1'b1) n_clr <= n_clr + 1;
      if (d_rx_valid === 1'b1) begin
         n_rx <= n_rx + 1;
         d_last <= d_rx_data;
         d_end <= d_rx_end;
      end
      if (cyc == 20000) begin
         num_errors++;
         test_done();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   function automatic logic sel(input int k);
      case (k)
         0: sel = c_tx_ready;
         1: sel = d_tx_ready;
         default: sel = c_rx_valid;
      endcase
   endfunction : sel
   task automatic wait_on(input int k);
      int w;
      w = 0;
      while (sel(k) !== 1'b1 && w < 400) begin
         @(negedge clk);
         w++;
      end
      if (w >= 400) chk("handshake", 8'h01, 8'h00);
   endtask : wait_on
   task automatic send(input logic [7:0] b, input logic a, input logic e);
      @(negedge clk);
      c_tx_data = b;
      c_tx_atn = a;
      c_tx_end = e;
      c_tx_valid = 1'b1;
      wait_on(0);
      @(negedge clk);
      c_tx_valid = 1'b0;
      wait_on(0);
      repeat (4) @(negedge clk);
   endtask : send
   task automatic seq(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
      send(a, 1'b1, 1'b0);
      send(b, 1'b1, 1'b0);
      send(c, 1'b1, 1'b0);
   endtask : seq
   task automatic dsend(input logic [7:0] b, input logic e);
      @(negedge clk);
      d_tx_data = b;
      d_tx_end = e;
      d_tx_valid = 1'b1;
      wait_on(1);
      @(negedge clk);
      d_tx_valid = 1'b0;
      wait_on(2);
      chk("ctl rx data", b, c_rx_data);
      chk("ctl rx end", 8'(e), 8'(c_rx_end));
   endtask : dsend
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_write;
      int r0, g0;
      r0 = n_rx;
      g0 = n_trig;
      seq(CT, CMD_UNL, DL);
      chk("listener", 8'h01, 8'(d_listener));
      send(CMD_GET, 1'b0, 1'b0);
      send(CMD_DCL, 1'b0, 1'b1);
      chk("rx count", 8'h02, 8'(n_rx - r0));
      chk("rx last", CMD_DCL, d_last);
      chk("rx end", 8'h01, 8'(d_end));
      chk("data as trigger", 8'h00, 8'(n_trig - g0));
   endtask : t_write
   task automatic t_trig;
      int g0;
      g0 = n_trig;
      send(CMD_GET, 1'b1, 1'b0);
      seq(CMD_UNL, CT, DL);
      send(CMD_GET, 1'b1, 1'b0);
      send(CMD_UNL, 1'b1, 1'b0);
      send(CMD_GET, 1'b1, 1'b0);
      chk("trigger count", 8'h02, 8'(n_trig - g0));
   endtask : t_trig
   task automatic t_clear;
      int c0;
      c0 = n_clr;
      send(CMD_DCL, 1'b1, 1'b0);
      seq(CMD_UNL, CT, DL);
      send(CMD_SDC, 1'b1, 1'b0);
      send(CMD_UNL, 1'b1, 1'b0);
      send(CMD_SDC, 1'b1, 1'b0);
      chk("clear count", 8'h02, 8'(n_clr - c0));
   endtask : t_clear
   task automatic t_read;
      seq(DL, CL, DT);
      chk("talker", 8'h01, 8'(d_talker));
      chk("unlisten on talk", 8'h00, 8'(d_listener));
      c_rx_en = 1'b1;
      dsend(8'h5A, 1'b0);
      dsend(8'hC3, 1'b1);
      c_rx_en = 1'b0;
      send(DL, 1'b1, 1'b0);
      chk("untalk on listen", 8'h00, 8'(d_talker));
      send(CMD_UNL, 1'b1, 1'b0);
   endtask : t_read
   task automatic t_poll;
      d_status = 8'h05;
      d_rsv = 1'b1;
      @(negedge clk);
      d_rsv = 1'b0;
      repeat (3) @(negedge clk);
      chk("srq", 8'h01, 8'(c_srq));
      seq(CMD_UNL, CL, DT);
      send(CMD_SPE, 1'b1, 1'b0);
      c_rx_en = 1'b1;
      wait_on(2);
      chk("status", 8'h45, c_rx_data);
      c_rx_en = 1'b0;
      send(CMD_SPD, 1'b1, 1'b0);
      send(CMD_UNT, 1'b1, 1'b0);
      chk("srq cleared", 8'h00, 8'(c_srq));
   endtask : t_poll
   task automatic t_remote;
      c_ren = 1'b1;
      seq(CMD_UNL, CT, DL);
      chk("remote", 8'h01, 8'(d_remote));
      send(CMD_LLO, 1'b1, 1'b0);
      chk("lockout", 8'h01, 8'(d_lockout));
      send(CMD_GTL, 1'b1, 1'b0);
      chk("local", 8'h00, 8'(d_remote));
      send(DL, 1'b1, 1'b0);
      c_ifc = 1'b1;
      repeat (4) @(negedge clk);
      c_ifc = 1'b0;
      repeat (4) @(negedge clk);
      chk("ifc listener", 8'h00, 8'(d_listener));
      chk("ifc remote", 8'h01, 8'(d_remote));
      c_ren = 1'b0;
      repeat (4) @(negedge clk);
      chk("ren off", 8'h00, 8'(d_remote));
   endtask : t_remote
   task automatic t_talk_trig;
      int g0;
      for (int m = 0; m < 3; m++) begin
         d_tma = (m == 0);
         d_tmb = (m == 1);
         g0 = n_trig;
         send(DT, 1'b1, 1'b0);
         send(CMD_UNT, 1'b1, 1'b0);
         send(L5, 1'b1, 1'b0);
         chk("talk trigger", 8'(m < 2), 8'(n_trig - g0));
         chk("other listen", 8'h00, 8'(d_listener));
      end
      d_tmb = 1'b0;
   endtask : t_talk_trig
   task automatic t_addr;
      d_addr = 5'h05;
      d_load = 1'b1;
      @(negedge clk);
      d_load = 1'b0;
      send(DL, 1'b1, 1'b0);
      chk("old address", 8'h00, 8'(d_listener));
      send(L5, 1'b1, 1'b0);
      chk("new address", 8'h01, 8'(d_listener));
      send(CMD_UNL, 1'b1, 1'b0);
   endtask : t_addr
   task automatic test_done;
      if (num_errors == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : test_done
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {clk, c_tx_valid, c_tx_atn, c_tx_end, c_rx_en, c_ifc, c_ren} = '0;
      {d_load, d_tma, d_tmb, d_tx_valid, d_tx_end, d_rsv} = '0;
      {c_tx_data, d_tx_data, d_status} = '0;
      d_addr = DEFAULT_ADDR;
      rst = 1'b1;
      repeat (10) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      t_write();
      t_trig();
      t_clear();
      t_read();
      t_poll();
      t_remote();
      t_talk_trig();
      t_addr();
      test_done();
   end
endmodule : gpib_instrument_interface_tb_top
